// ---- opaddr_consts.svh ----
/*
  constants for the operand addressing register file: sizes, field
  positions, masks and reset values.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef OPADDR_CONSTS_SVH
`define OPADDR_CONSTS_SVH

// register file shape
`define OA_NREG 16
`define OA_RNUM_W 4
`define OA_WORD_W 16
`define OA_BYTE_W 8
`define OA_SEG_W 7
`define OA_DATA_W 64
`define OA_ADDR_W 32

// reset content of every word register
`define OA_RESET_WORD 16'h0000
`define OA_ZERO_REG 4'h0

// segmented address field layout, long form (32 bits)
`define OA_LONG_FLAG 31
`define OA_LONG_SEG_HI 30
`define OA_LONG_SEG_LO 24
`define OA_LONG_PAD_HI 23
`define OA_LONG_PAD_LO 16
// segmented address field layout, short form (16 bits)
`define OA_SHORT_SEG_HI 14
`define OA_SHORT_SEG_LO 8
`define OA_SHORT_OFF_HI 7
`define OA_SHORT_OFF_LO 0
`define OA_ZERO_BYTE 8'h00

// immediate truncation masks
`define OA_IMM4_MASK 32'h0000000f
`define OA_IMM8_MASK 32'h000000ff
`define OA_IMM16_MASK 32'h0000ffff
`define OA_IMM32_MASK 32'hffffffff

`endif

// ---- opaddr_pkg.sv ----
/*
  types shared by the operand addressing register file: modes, sizes,
  instruction classes and the request / answer carriers.
  assumes opaddr_consts.svh is on the include path.
*/
`include "opaddr_consts.svh"

package opaddr_pkg;

  // operand addressing mode
  typedef enum logic [1:0] {MD_IMM, MD_REG, MD_IND, MD_DIR} mode_e;
  // operand size taken from the instruction
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD} size_e;
  // instruction class, only the three 64-bit ones may use a quadruple
  typedef enum logic [1:0] {
    IC_PLAIN, IC_DIVIDE_LONG, IC_SIGN_EXTEND_LONG, IC_MULTIPLY_LONG
  } iclass_e;
  // how many low bits of an immediate are used
  typedef enum logic [1:0] {IW_4, IW_8, IW_16, IW_32} immw_e;

  typedef logic [`OA_WORD_W-1:0] word_t;
  typedef logic [`OA_DATA_W-1:0] data_t;

  // request from the instruction decoder
  typedef struct packed {
    logic valid;
    logic wr;
    mode_e mode;
    size_e size;
    iclass_e iclass;
    immw_e immw;
    logic io;
    logic seg;
    logic [`OA_RNUM_W-1:0] rnum;
    logic [`OA_ADDR_W-1:0] imm;
    logic [`OA_ADDR_W-1:0] afield;
    data_t wdata;
  } req_s;

  // resolved operand or address
  typedef struct packed {
    logic valid;
    logic illegal;
    logic has_addr;
    logic io;
    logic seg;
    logic [`OA_SEG_W-1:0] segnum;
    word_t offset;
    data_t data;
  } ans_s;

endpackage : opaddr_pkg

// ---- seg_addr_former.sv ----
/*
  splits a segmented address word into segment number and offset, for
  either the long form or, when allowed, the short form.
  assumes a purely combinational use inside the register file.
*/
`include "opaddr_consts.svh"

module seg_addr_former (
  // address as stored or encoded
  input wire logic [`OA_ADDR_W-1:0] field,
  input wire logic allow_short,
  // split result
  output logic [`OA_SEG_W-1:0] segnum,
  output logic [`OA_WORD_W-1:0] offset,
  output logic bad
);

  // long or short form decided by the flag bit alone
  always_comb begin
    // [RL14] long form layout
    if (field[`OA_LONG_FLAG]) begin
      segnum = field[`OA_LONG_SEG_HI:`OA_LONG_SEG_LO];
      offset = field[`OA_WORD_W-1:0];
      // pad byte must be clear, else the word is not a valid long address
      bad = (field[`OA_LONG_PAD_HI:`OA_LONG_PAD_LO] != `OA_ZERO_BYTE);
    end else begin
      // [RL15] short form packed word
      segnum = field[`OA_SHORT_SEG_HI:`OA_SHORT_SEG_LO];
      // [RL13] offset only 0 to 255
      offset = {`OA_ZERO_BYTE, field[`OA_SHORT_OFF_HI:`OA_SHORT_OFF_LO]};
      // a register pair always holds the long form
      bad = !allow_short;
    end
  end

endmodule : seg_addr_former

// ---- operand_addressing_regfile.sv ----
/*
  sixteen word general register file with byte, pair and quadruple
  views, plus resolution of immediate, register, indirect and direct
  operands into data or (segmented) addresses.
  assumes the instruction decoder drives req synchronously to ref_clk
  and reads ans one cycle later; bus cycles happen elsewhere.
*/
// How it works
// [RL1] sixteen word registers, any readable and writable
// [RL2] byte views of registers 0-7, other byte kept
// [RL3] pairs start at even number only
// [RL4] quads start at 0, 4, 8, 12 only
// [RL5] quads only for the three long instructions
// [RL6] register width follows instruction size
// [RL7] immediate uses its low 4/8/16/32 bits
// [RL8] indirect memory via word or pair, not zero
// [RL9] indirect io address from word 1-15
// [RL10] direct address 16 bits nonsegmented and io
// [RL11] segmented direct takes short or long form
// [RL12] long form: 7-bit segment, 16-bit offset
// [RL13] short form offset limited to 0-255
// [RL14] long high word: flag set, low byte zero
// [RL15] short form flagged by clear top bit
// [RL16] bad register numbers reported as illegal
`include "opaddr_consts.svh"

module operand_addressing_regfile (
  // clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // request from the decoder
  input wire opaddr_pkg::req_s req,
  // resolved operand, one cycle after the request
  output opaddr_pkg::ans_s ans
);

  // register array and its next value
  opaddr_pkg::word_t regs_q [`OA_NREG];
  opaddr_pkg::word_t regs_d [`OA_NREG];
  // registered answer
  opaddr_pkg::ans_s ans_q;
  opaddr_pkg::ans_s ans_d;

  // register number views
  logic [`OA_RNUM_W-1:0] rn;
  logic [`OA_RNUM_W-1:0] pair_hi;
  logic [`OA_RNUM_W-1:0] pair_lo;
  logic [`OA_RNUM_W-1:0] quad_0;
  logic [`OA_RNUM_W-1:0] quad_1;
  logic [`OA_RNUM_W-1:0] quad_2;
  logic [`OA_RNUM_W-1:0] quad_3;
  logic [2:0] bsel; // byte register's word
  logic blow; // low byte selected
  logic is_zero; // register zero named

  // legality checks
  logic pair_bad;
  logic quad_bad;
  logic reg_bad;
  logic illegal;
  logic do_write;

  // segmented address splits
  logic [`OA_SEG_W-1:0] ind_seg;
  opaddr_pkg::word_t ind_off;
  logic ind_fmt_bad;
  logic [`OA_SEG_W-1:0] dir_seg;
  opaddr_pkg::word_t dir_off;
  logic dir_fmt_bad;

  // helper state for the byte preservation check only
  logic [`OA_BYTE_W-1:0] keep_q;
  logic [2:0] keep_sel_q;
  logic keep_low_q;
  logic keep_chk_q;

  // register numbers of pair and quad members come from bit slicing so
  // an odd start never wraps into a neighbouring group
  always_comb begin
    rn = req.rnum;
    bsel = rn[2:0];
    blow = rn[`OA_RNUM_W-1];
    is_zero = (rn == `OA_ZERO_REG);
    pair_hi = {rn[3:1], 1'h0};
    pair_lo = {rn[3:1], 1'h1};
    quad_0 = {rn[3:2], 2'h0};
    quad_1 = {rn[3:2], 2'h1};
    quad_2 = {rn[3:2], 2'h2};
    quad_3 = {rn[3:2], 2'h3};
  end

  // pair contents read as a long-form segmented address
  // [RL8] segmented indirect via pair
  seg_addr_former ind_former (
    .field({regs_q[pair_hi], regs_q[pair_lo]}),
    .allow_short(1'h0),
    .segnum(ind_seg),
    .offset(ind_off),
    .bad(ind_fmt_bad)
  );

  // instruction address field, either form accepted
  // [RL11] short or long direct
  seg_addr_former dir_former (
    .field(req.afield),
    .allow_short(1'h1),
    .segnum(dir_seg),
    .offset(dir_off),
    .bad(dir_fmt_bad)
  );

  // legality of the register number for the requested view
  always_comb begin
    // [RL3] odd pair start refused
    pair_bad = rn[0];
    // [RL4] quad start must be a multiple of four
    // [RL5] quads reserved for the long instructions
    quad_bad = (rn[1:0] != 2'h0) || (req.iclass == opaddr_pkg::IC_PLAIN);
    // [RL6] view picked by the instruction size
    case (req.size)
      opaddr_pkg::SZ_LONG: reg_bad = pair_bad;
      opaddr_pkg::SZ_QUAD: reg_bad = quad_bad;
      default: reg_bad = 1'h0;
    endcase
    // [RL16] mode specific refusals
    case (req.mode)
      opaddr_pkg::MD_REG: illegal = reg_bad;
      opaddr_pkg::MD_IND: begin
        if (req.io || !req.seg) begin
          // [RL9] register zero never an address
          illegal = is_zero;
        end else begin
          // [RL8] pair zero and odd pairs refused
          illegal = is_zero || pair_bad || ind_fmt_bad;
        end
      end
      opaddr_pkg::MD_DIR: illegal = req.seg && !req.io && dir_fmt_bad;
      default: illegal = 1'h0;
    endcase
    // writes only through a legal register operand
    do_write = req.valid && req.wr && (req.mode == opaddr_pkg::MD_REG) && !illegal;
  end

  // next register contents
  always_comb begin
    for (int i = 0; i < `OA_NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (do_write) begin
      case (req.size)
        // [RL2] byte write keeps the other byte
        opaddr_pkg::SZ_BYTE: begin
          if (blow) begin
            regs_d[bsel] = {regs_q[bsel][`OA_WORD_W-1:`OA_BYTE_W], req.wdata[`OA_BYTE_W-1:0]};
          end else begin
            regs_d[bsel] = {req.wdata[`OA_BYTE_W-1:0], regs_q[bsel][`OA_BYTE_W-1:0]};
          end
        end
        // [RL1] plain word write
        opaddr_pkg::SZ_WORD: regs_d[rn] = req.wdata[`OA_WORD_W-1:0];
        // [RL3] pair, high word in the even register
        opaddr_pkg::SZ_LONG: begin
          regs_d[pair_hi] = req.wdata[31:16];
          regs_d[pair_lo] = req.wdata[15:0];
        end
        // [RL4] quad, most significant word first
        opaddr_pkg::SZ_QUAD: begin
          regs_d[quad_0] = req.wdata[63:48];
          regs_d[quad_1] = req.wdata[47:32];
          regs_d[quad_2] = req.wdata[31:16];
          regs_d[quad_3] = req.wdata[15:0];
        end
        default: regs_d[rn] = regs_q[rn];
      endcase
    end
  end

  // answer for the current request
  always_comb begin
    ans_d = '0;
    ans_d.valid = req.valid;
    ans_d.illegal = req.valid && illegal;
    ans_d.io = req.io;
    ans_d.seg = req.seg && !req.io;
    case (req.mode)
      // [RL7] immediate truncated to its used width
      opaddr_pkg::MD_IMM: begin
        case (req.immw)
          opaddr_pkg::IW_4: ans_d.data = opaddr_pkg::data_t'(req.imm & `OA_IMM4_MASK);
          opaddr_pkg::IW_8: ans_d.data = opaddr_pkg::data_t'(req.imm & `OA_IMM8_MASK);
          opaddr_pkg::IW_16: ans_d.data = opaddr_pkg::data_t'(req.imm & `OA_IMM16_MASK);
          default: ans_d.data = opaddr_pkg::data_t'(req.imm & `OA_IMM32_MASK);
        endcase
      end
      // [RL6] register read at the instruction's width
      opaddr_pkg::MD_REG: begin
        case (req.size)
          opaddr_pkg::SZ_BYTE: begin
            // [RL2] byte read from registers 0-7
            if (blow) begin
              ans_d.data = opaddr_pkg::data_t'(regs_q[bsel][`OA_BYTE_W-1:0]);
            end else begin
              ans_d.data = opaddr_pkg::data_t'(regs_q[bsel][`OA_WORD_W-1:`OA_BYTE_W]);
            end
          end
          opaddr_pkg::SZ_WORD: ans_d.data = opaddr_pkg::data_t'(regs_q[rn]);
          opaddr_pkg::SZ_LONG: ans_d.data = opaddr_pkg::data_t'({regs_q[pair_hi], regs_q[pair_lo]});
          default: ans_d.data = {regs_q[quad_0], regs_q[quad_1], regs_q[quad_2], regs_q[quad_3]};
        endcase
      end
      // indirect: address held in a register
      opaddr_pkg::MD_IND: begin
        ans_d.has_addr = 1'h1;
        if (req.io || !req.seg) begin
          // [RL9] io and nonsegmented take a word register
          ans_d.offset = regs_q[rn];
        end else begin
          ans_d.segnum = ind_seg;
          ans_d.offset = ind_off;
        end
      end
      // direct: address from the instruction
      default: begin
        ans_d.has_addr = 1'h1;
        if (req.io || !req.seg) begin
          // [RL10] only the low 16 bits count
          ans_d.offset = req.afield[`OA_WORD_W-1:0];
        end else begin
          // [RL12] segment and offset of either form, full 16 bits long, 0-255 short
          ans_d.segnum = dir_seg;
          ans_d.offset = dir_off;
        end
      end
    endcase
    // illegal operands carry no data, so nothing runs on garbage
    if (ans_d.illegal) begin
      ans_d.data = '0;
      ans_d.offset = '0;
      ans_d.segnum = '0;
    end
  end

  // state update, frozen while clk_en is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `OA_NREG; i++) begin
        regs_q[i] <= `OA_RESET_WORD;
      end
      ans_q <= '0;
    end else if (clk_en) begin
      regs_q <= regs_d;
      ans_q <= ans_d;
    end
  end

  assign ans = ans_q;

  // snapshot of the untouched byte for the check below
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      keep_q <= `OA_ZERO_BYTE;
      keep_sel_q <= 3'h0;
      keep_low_q <= 1'h0;
      keep_chk_q <= 1'h0;
    end else if (clk_en) begin
      keep_q <= blow ? regs_q[bsel][`OA_WORD_W-1:`OA_BYTE_W] : regs_q[bsel][`OA_BYTE_W-1:0];
      keep_sel_q <= bsel;
      keep_low_q <= blow;
      keep_chk_q <= do_write && (req.size == opaddr_pkg::SZ_BYTE);
    end
  end

  // [RL2] other byte unchanged
  byte_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
    keep_chk_q |-> (keep_low_q ? regs_q[keep_sel_q][`OA_WORD_W-1:`OA_BYTE_W]
      : regs_q[keep_sel_q][`OA_BYTE_W-1:0]) == keep_q)
    else $error("byte write disturbed the other byte");

  // [RL3] odd pair refused
  pair_odd_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_REG
      && req.size == opaddr_pkg::SZ_LONG && req.rnum[0] |=> ans_q.illegal)
    else $error("odd pair not flagged");

  // [RL4] misaligned quad refused
  quad_align_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_REG
      && req.size == opaddr_pkg::SZ_QUAD && req.rnum[1:0] != 2'h0 |=> ans_q.illegal)
    else $error("misaligned quad not flagged");

  // [RL5] quad with plain instruction refused
  quad_class_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_REG && req.size == opaddr_pkg::SZ_QUAD
      && req.iclass == opaddr_pkg::IC_PLAIN |=> ans_q.illegal && ans_q.data == '0)
    else $error("quad used by a plain instruction");

  // [RL7] four bit immediate
  imm_four_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL7]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_IMM && req.immw == opaddr_pkg::IW_4
      |=> ans_q.data == opaddr_pkg::data_t'($past(req.imm) & `OA_IMM4_MASK))
    else $error("immediate not truncated to 4 bits");

  // [RL9] register zero as address
  ind_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_IND && req.rnum == `OA_ZERO_REG
      |=> ans_q.illegal ##1 (!clk_en || !$past(req.valid) || ans_q.valid))
    else $error("register zero accepted as address");

  // [RL10] io direct address
  io_direct_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL10]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_DIR && req.io
      |=> !ans_q.illegal && !ans_q.seg && ans_q.offset == $past(req.afield[15:0]))
    else $error("io direct address wrong");

  // [RL12] long form split
  long_form_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_DIR && req.seg && !req.io
      && req.afield[31] && req.afield[23:16] == 8'h00
      |=> !ans_q.illegal && ans_q.segnum == $past(req.afield[30:24])
        && ans_q.offset == $past(req.afield[15:0]))
    else $error("long form address split wrong");

  // [RL13] short form offset bound
  short_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RL13]
    clk_en && req.valid && req.mode == opaddr_pkg::MD_DIR && req.seg && !req.io
      && !req.afield[`OA_LONG_FLAG] |=> !ans_q.illegal && ans_q.offset[15:8] == 8'h00
        && ans_q.segnum == $past(req.afield[14:8]))
    else $error("short form offset out of range");

endmodule : operand_addressing_regfile

// ---- operand_addressing_regfile_test.sv ----
/*
  self-checking bench for the operand addressing register file: one
  request per enabled edge, each answer judged on the following cycle.
  assumes opaddr_pkg is compiled first and a fixed one-edge latency.
*/
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, (exp), (got)); end end

module operand_addressing_regfile_test;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset and enable
  logic ref_clk = 1'b0;
  logic rst = 1'b1; // high from time zero
  logic clk_en = 1'b1; // dropped once to see the freeze
  // request and answer
  opaddr_pkg::req_s req = '0;
  opaddr_pkg::ans_s ans;
  opaddr_pkg::req_s r; // request being built
  // tallies for the verdict
  int failures = 0;
  int cmp_count = 0;

  operand_addressing_regfile uut (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .req(req),
    .ans(ans)
  );

  // 50 MHz
  always #10 ref_clk = ~ref_clk;

  // per-register pattern, nibbles encode the index
  function automatic opaddr_pkg::word_t val(input int i);
    return {4'ha, i[3:0], ~i[3:0], 4'h5};
  endfunction : val

  // fresh register-mode request, other fields cleared
  task automatic clr(input opaddr_pkg::size_e s, input logic [3:0] n);
    r = '0;
    r.valid = 1'b1;
    r.mode = opaddr_pkg::MD_REG;
    r.size = s;
    r.rnum = n;
  endtask : clr

  // present r; the request is held until the next one replaces it
  task automatic go();
    req = r;
    @(posedge ref_clk);
    #1;
  endtask : go

  task automatic rd(input opaddr_pkg::size_e s, input logic [3:0] n);
    clr(s, n);
    go();
  endtask : rd

  task automatic wr(input opaddr_pkg::size_e s, input logic [3:0] n, input opaddr_pkg::data_t d);
    clr(s, n);
    r.wr = 1'b1;
    r.wdata = d;
    go();
  endtask : wr

  // indirect or direct address request
  task automatic aop(input opaddr_pkg::mode_e m, input logic [3:0] n, input logic io,
                     input logic seg, input logic [31:0] af);
    clr(opaddr_pkg::SZ_WORD, n);
    r.mode = m;
    r.io = io;
    r.seg = seg;
    r.afield = af;
    go();
  endtask : aop

  // refused operand: flag up, payload cleared
  task automatic bad(input string nm);
    `CHK(nm, {2'b11, 87'h0}, {ans.valid, ans.illegal, ans.data, ans.offset, ans.segnum})
  endtask : bad

  // resolved address: flags, segment number and offset
  task automatic adr(input string nm, input logic io, input logic seg,
                     input logic [6:0] sn, input opaddr_pkg::word_t off);
    `CHK(nm, {3'b101, io, seg, sn, off},
         {ans.valid, ans.illegal, ans.has_addr, ans.io, ans.seg, ans.segnum, ans.offset})
  endtask : adr

  task automatic t_words();
    for (int i = 0; i < 16; i++) begin
      wr(opaddr_pkg::SZ_WORD, i[3:0], {48'h0, val(i)});
      `CHK("old word", 64'h0, ans.data)
    end
    for (int i = 0; i < 16; i++) begin
      rd(opaddr_pkg::SZ_WORD, i[3:0]);
      `CHK("word", {2'b10, 48'h0, val(i)}, {ans.valid, ans.illegal, ans.data})
    end
  endtask : t_words

  // byte halves of word 2, other half kept
  task automatic t_bytes();
    wr(opaddr_pkg::SZ_BYTE, 4'h2, 64'h3c);
    wr(opaddr_pkg::SZ_BYTE, 4'ha, 64'hc3);
    rd(opaddr_pkg::SZ_WORD, 4'h2);
    `CHK("bytes merged", 64'h3cc3, ans.data)
    rd(opaddr_pkg::SZ_BYTE, 4'ha);
    `CHK("low byte", 64'hc3, ans.data)
    rd(opaddr_pkg::SZ_BYTE, 4'h2);
    `CHK("high byte", 64'h3c, ans.data)
  endtask : t_bytes

  // pairs from even numbers, odd refused and write dropped
  task automatic t_pairs();
    rd(opaddr_pkg::SZ_LONG, 4'h4);
    `CHK("pair", {32'h0, val(4), val(5)}, ans.data)
    rd(opaddr_pkg::SZ_LONG, 4'hf);
    bad("odd pair read");
    wr(opaddr_pkg::SZ_LONG, 4'h7, 64'h1111_2222);
    bad("odd pair write");
    rd(opaddr_pkg::SZ_WORD, 4'h7);
    `CHK("dropped write", {48'h0, val(7)}, ans.data)
    wr(opaddr_pkg::SZ_LONG, 4'h6, 64'hdead_beef);
    rd(opaddr_pkg::SZ_WORD, 4'h7);
    `CHK("pair low word", 64'hbeef, ans.data)
  endtask : t_pairs

  // quads only at 0/4/8/12 and only for long classes
  task automatic t_quads();
    for (int k = 1; k < 4; k++) begin
      clr(opaddr_pkg::SZ_QUAD, 4'h8);
      r.iclass = opaddr_pkg::iclass_e'(k[1:0]);
      go();
      `CHK("quad", {val(8), val(9), val(10), val(11)}, ans.data)
    end
    clr(opaddr_pkg::SZ_QUAD, 4'h6);
    r.iclass = opaddr_pkg::IC_MULTIPLY_LONG;
    go();
    bad("quad start");
    rd(opaddr_pkg::SZ_QUAD, 4'hc);
    bad("quad plain class");
  endtask : t_quads

  // immediate cut to 4, 8, 16 or 32 bits
  task automatic t_imm();
    for (int k = 0; k < 4; k++) begin
      clr(opaddr_pkg::SZ_LONG, 4'h0);
      r.mode = opaddr_pkg::MD_IMM;
      r.immw = opaddr_pkg::immw_e'(k[1:0]);
      r.imm = 32'h89abcdef;
      go();
      `CHK("imm", 64'h89abcdef & ((64'h1 << (4 << k)) - 64'h1), ans.data)
    end
  endtask : t_imm

  // indirect through word or pair, never register zero
  task automatic t_ind();
    aop(opaddr_pkg::MD_IND, 4'h3, 1'b0, 1'b0, 32'h0);
    adr("ind word", 1'b0, 1'b0, 7'h0, val(3));
    aop(opaddr_pkg::MD_IND, 4'hf, 1'b1, 1'b1, 32'h0);
    adr("ind io", 1'b1, 1'b0, 7'h0, val(15));
    for (int j = 0; j < 4; j++) begin
      aop(opaddr_pkg::MD_IND, 4'h0, j[1], j[0], 32'h0);
      bad("ind zero");
    end
    wr(opaddr_pkg::SZ_LONG, 4'h2, 64'h8300_1234);
    aop(opaddr_pkg::MD_IND, 4'h2, 1'b0, 1'b1, 32'h0);
    adr("ind pair", 1'b0, 1'b1, 7'h3, 16'h1234);
    aop(opaddr_pkg::MD_IND, 4'h3, 1'b0, 1'b1, 32'h0);
    bad("ind odd pair");
    wr(opaddr_pkg::SZ_LONG, 4'h2, 64'h0300_1234);
    aop(opaddr_pkg::MD_IND, 4'h2, 1'b0, 1'b1, 32'h0);
    bad("ind no flag");
    wr(opaddr_pkg::SZ_LONG, 4'h2, 64'h8301_1234);
    aop(opaddr_pkg::MD_IND, 4'h2, 1'b0, 1'b1, 32'h0);
    bad("ind pad");
  endtask : t_ind

  // direct plain, io, long and short forms
  task automatic t_dir();
    aop(opaddr_pkg::MD_DIR, 4'h0, 1'b0, 1'b0, 32'h0005abcd);
    adr("dir plain", 1'b0, 1'b0, 7'h0, 16'habcd);
    aop(opaddr_pkg::MD_DIR, 4'h0, 1'b1, 1'b1, 32'h8300_0077);
    adr("dir io", 1'b1, 1'b0, 7'h0, 16'h0077);
    aop(opaddr_pkg::MD_DIR, 4'h0, 1'b0, 1'b1, 32'hff00_ffff);
    adr("dir long", 1'b0, 1'b1, 7'h7f, 16'hffff);
    aop(opaddr_pkg::MD_DIR, 4'h0, 1'b0, 1'b1, 32'h0000_7fff);
    adr("dir short", 1'b0, 1'b1, 7'h7f, 16'h00ff);
    aop(opaddr_pkg::MD_DIR, 4'h0, 1'b0, 1'b1, 32'h8380_1234);
    bad("dir pad");
  endtask : t_dir

  // enable low freezes registers and answer alike
  task automatic t_hold();
    rd(opaddr_pkg::SZ_WORD, 4'h6);
    clk_en = 1'b0;
    wr(opaddr_pkg::SZ_WORD, 4'h6, 64'h5a5a);
    `CHK("frozen ans", 64'hdead, ans.data)
    clk_en = 1'b1;
    rd(opaddr_pkg::SZ_WORD, 4'h6);
    `CHK("frozen reg", 64'hdead, ans.data)
  endtask : t_hold

  // reset in mid-run clears answer and registers
  task automatic t_reset();
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("reset ans", '0, ans)
    rst = 1'b0;
    rd(opaddr_pkg::SZ_WORD, 4'h5);
    `CHK("reset reg", 64'h0, ans.data)
  endtask : t_reset

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_words();
    t_bytes();
    t_pairs();
    t_quads();
    t_imm();
    t_ind();
    t_dir();
    t_hold();
    t_reset();
    final_report();
  end

  // hang guard, far beyond the roughly 80 cycles needed
  initial begin
    #1ms;
    failures++;
    final_report();
  end
endmodule : operand_addressing_regfile_test
